/* rtl/p3m_params.svh */
// Constants for the port 3 pin function selector: offsets, fields, resets.
// Assumes inclusion by bare name from the rtl/ and dv/ files that need it.
`ifndef P3M_PARAMS_SVH
`define P3M_PARAMS_SVH

// Register word offsets (byte addresses)
`define P3M_OFS_TIMER 8'h00
`define P3M_OFS_SERIAL 8'h04
`define P3M_OFS_UART 8'h08
`define P3M_OFS_PORT 8'h0C
`define P3M_OFS_STATUS 8'h10

// Writable bits of each configuration word
`define P3M_MASK_TIMER 16'h007F
`define P3M_MASK_SERIAL 16'h00FF
`define P3M_MASK_UART 16'h01FF
`define P3M_MASK_PORT 16'h03FF

// Reset values
`define P3M_RST_TIMER 16'h0000
`define P3M_RST_SERIAL 16'h0000
`define P3M_RST_UART 16'h0000
`define P3M_RST_PORT 16'h0000

// Timer word fields
`define P3M_TMR_CHD_SEL 0
`define P3M_TMR_OUT_EN_CTRL 1
`define P3M_TMR_MODE_A 2
`define P3M_TMR_CHD_PWM 3
`define P3M_TMR_CHD_IO_LSB 4

// Serial word fields
`define P3M_SER_CLK_OD 0
`define P3M_SER_DATA_OD 1
`define P3M_SER_I2C_SEL 2
`define P3M_SER_DATA_PIN_SEL 3
`define P3M_SER_DATA_OUT_CTL 4
`define P3M_SER_DATA_IN_CTL 5
`define P3M_SER_CLK_OUT_CTL 6
`define P3M_SER_CLK_IN_CTL 7

// UART word fields
`define P3M_UART_TX_EN 0
`define P3M_UART_MODE_LSB 1
`define P3M_UART_ROUTE_LSB 4
`define P3M_UART_ALT_PIN 6
`define P3M_UART_TX_ALT 7
`define P3M_UART_OD 8

// Port word fields
`define P3M_PORT_DIR_LSB 0
`define P3M_PORT_DATA_LSB 3
`define P3M_PORT_IRQ1_EN 6
`define P3M_PORT_IRQ1_SEL 7
`define P3M_PORT_PULLUP 8
`define P3M_PORT_TMRA_OE 9

`endif

/* rtl/p3m_pkg.sv */
// Types shared by the port 3 pin function selector.
// Assumes nothing beyond a SystemVerilog compiler.
`default_nettype none

package p3m_pkg;

  // Function currently given to a pin
  typedef enum logic [3:0] {
    FN_PORT_IN,
    FN_PORT_OUT,
    FN_PWM,
    FN_COMPARE,
    FN_CAPTURE,
    FN_SERCLK_OUT,
    FN_SERCLK_IN,
    FN_IRQ,
    FN_UART_TX,
    FN_UART_RX,
    FN_SDATA_OUT,
    FN_SDATA_IN,
    FN_TIMERA
  } p3m_func_t;

endpackage : p3m_pkg

`default_nettype wire

/* rtl/p3m_pin_drive.sv */
// One pin's output stage: registers drive level, enable and pull-up.
// Assumes the decoded function comes from the selector in sys_clk domain.
`default_nettype none

module p3m_pin_drive (
  input wire logic sys_clk,
  input wire logic rst_n,
  input wire logic drive,
  input wire logic data,
  input wire logic openDrain,
  input wire logic pullAllow,
  output logic pinOut,
  output logic pinOe,
  output logic pullEn
);
  import p3m_pkg::*;

  logic oeD;

  // Open drain only pulls low; a high level releases the pin
  assign oeD = drive & ~(openDrain & data);

  // ********************************
  // Output registers
  // ********************************
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      pinOut <= 1'b0;
      pinOe <= 1'b0;
      pullEn <= 1'b0;
    end else begin
      pinOut <= data;
      pinOe <= oeD;
      pullEn <= ~drive & pullAllow;
    end
  end

endmodule : p3m_pin_drive

`default_nettype wire

/* rtl/p3m_pin_select.sv */
// Port 3 upper pin function selector with a classic Wishbone slave.
// Assumes on-chip peripherals and a Wishbone master on sys_clk.
// Pin index 0 is port 3 bit 5, index 1 is bit 6, index 2 is bit 7.
//
// The Wishbone register port and the register addresses were left to the implementer.
`default_nettype none

`include "p3m_params.svh"

module p3m_pin_select #(
  parameter int ADDR_W = 8,
  parameter int NUM_PINS = 3
) (
  input wire logic sys_clk,
  input wire logic rst_n,
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_we_i,
  input wire logic [ADDR_W-1:0] wb_adr_i,
  input wire logic [3:0] wb_sel_i,
  input wire logic [31:0] wb_dat_i,
  output logic [31:0] wb_dat_o,
  output logic wb_ack_o,
  input wire logic [NUM_PINS-1:0] pinIn,
  output logic [NUM_PINS-1:0] pinOut,
  output logic [NUM_PINS-1:0] pinOe,
  output logic [NUM_PINS-1:0] pullupEn,
  input wire logic timerChdPwmWave,
  input wire logic timerChdCmpWave,
  output logic timerChdCapture,
  input wire logic syncSerialClockOut,
  output logic syncSerialClockIn,
  input wire logic syncSerialDataOut,
  output logic syncSerialDataIn,
  input wire logic timeraOutWave,
  input wire logic uart1TransmitData,
  output logic uart1ReceiveData,
  output logic externalIrq1
);
  import p3m_pkg::*;

  // Refuse sizes the decoder cannot serve
  if (NUM_PINS != 3) begin : gBadPins
    $error("p3m_pin_select serves exactly three pins");
  end
  if (ADDR_W < 5) begin : gBadAdr
    $error("p3m_pin_select needs at least 5 address bits");
  end

  // ****************************************
  // Wishbone slave and configuration words
  // ****************************************
  logic [15:0] cfgQ [4];
  logic ackQ;
  logic [31:0] rdQ;
  logic req;
  logic wrEn;
  logic [7:0] adr8;
  logic [3:0] hit;
  logic hitStatus;
  logic [15:0] lane;
  logic [15:0] mask [4];
  logic [15:0] statusWord;
  logic [31:0] rdD;

  assign req = wb_cyc_i & wb_stb_i & ~ackQ;
  // Writes land on the edge where the master samples acknowledge high
  assign wrEn = wb_cyc_i & wb_stb_i & wb_we_i & ackQ;
  assign adr8 = 8'(wb_adr_i);
  assign hit[0] = adr8 == `P3M_OFS_TIMER;
  assign hit[1] = adr8 == `P3M_OFS_SERIAL;
  assign hit[2] = adr8 == `P3M_OFS_UART;
  assign hit[3] = adr8 == `P3M_OFS_PORT;
  assign hitStatus = adr8 == `P3M_OFS_STATUS;
  assign lane = {{8{wb_sel_i[1]}}, {8{wb_sel_i[0]}}};
  assign mask[0] = `P3M_MASK_TIMER;
  assign mask[1] = `P3M_MASK_SERIAL;
  assign mask[2] = `P3M_MASK_UART;
  assign mask[3] = `P3M_MASK_PORT;

  // Read selection; unmapped addresses read zero
  assign rdD = hit[0] ? {16'h0000, cfgQ[0]} :
               hit[1] ? {16'h0000, cfgQ[1]} :
               hit[2] ? {16'h0000, cfgQ[2]} :
               hit[3] ? {16'h0000, cfgQ[3]} :
               hitStatus ? {16'h0000, statusWord} : 32'h0000_0000;

  // One-cycle answer to every request, mapped or not
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      ackQ <= 1'b0;
      rdQ <= 32'h0000_0000;
    end else begin
      ackQ <= req;
      rdQ <= req ? rdD : rdQ;
    end
  end

  // Configuration words, written with byte lanes on the acknowledge edge
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      cfgQ[0] <= `P3M_RST_TIMER;
      cfgQ[1] <= `P3M_RST_SERIAL;
      cfgQ[2] <= `P3M_RST_UART;
      cfgQ[3] <= `P3M_RST_PORT;
    end else begin
      for (int i = 0; i < 4; i++) begin
        if (wrEn && hit[i]) begin
          cfgQ[i] <= (cfgQ[i] & ~(lane & mask[i])) |
                     (wb_dat_i[15:0] & lane & mask[i]);
        end
      end
    end
  end

  assign wb_ack_o = ackQ;
  assign wb_dat_o = rdQ;

  // ********************************
  // Configuration fields
  // ********************************
  logic chdSel, outEnCtl, modeA, chdPwm;
  logic [2:0] chdIo;
  logic clkOd, dataOd, i2cSel, dataPinSel;
  logic dataOutCtl, dataInCtl, clkOutCtl, clkInCtl;
  logic txEn, altPin, txAlt, uartOd;
  logic [2:0] uartMode;
  logic [1:0] route;
  logic [2:0] dir, portData;
  logic irq1En, irq1Sel, pullupBit, timeraOe;

  assign chdSel = cfgQ[0][`P3M_TMR_CHD_SEL];
  assign outEnCtl = cfgQ[0][`P3M_TMR_OUT_EN_CTRL];
  assign modeA = cfgQ[0][`P3M_TMR_MODE_A];
  assign chdPwm = cfgQ[0][`P3M_TMR_CHD_PWM];
  assign chdIo = cfgQ[0][`P3M_TMR_CHD_IO_LSB +: 3];
  assign clkOd = cfgQ[1][`P3M_SER_CLK_OD];
  assign dataOd = cfgQ[1][`P3M_SER_DATA_OD];
  assign i2cSel = cfgQ[1][`P3M_SER_I2C_SEL];
  assign dataPinSel = cfgQ[1][`P3M_SER_DATA_PIN_SEL];
  assign dataOutCtl = cfgQ[1][`P3M_SER_DATA_OUT_CTL];
  assign dataInCtl = cfgQ[1][`P3M_SER_DATA_IN_CTL];
  assign clkOutCtl = cfgQ[1][`P3M_SER_CLK_OUT_CTL];
  assign clkInCtl = cfgQ[1][`P3M_SER_CLK_IN_CTL];
  assign txEn = cfgQ[2][`P3M_UART_TX_EN];
  assign uartMode = cfgQ[2][`P3M_UART_MODE_LSB +: 3];
  assign route = cfgQ[2][`P3M_UART_ROUTE_LSB +: 2];
  assign altPin = cfgQ[2][`P3M_UART_ALT_PIN];
  assign txAlt = cfgQ[2][`P3M_UART_TX_ALT];
  assign uartOd = cfgQ[2][`P3M_UART_OD];
  assign dir = cfgQ[3][`P3M_PORT_DIR_LSB +: 3];
  assign portData = cfgQ[3][`P3M_PORT_DATA_LSB +: 3];
  assign irq1En = cfgQ[3][`P3M_PORT_IRQ1_EN];
  assign irq1Sel = cfgQ[3][`P3M_PORT_IRQ1_SEL];
  assign pullupBit = cfgQ[3][`P3M_PORT_PULLUP];
  assign timeraOe = cfgQ[3][`P3M_PORT_TMRA_OE];

  // ********************************
  // Function decode
  // ********************************
  logic chdPwmOn, chdCmpOn, chdCapOn, clkOutOn, clkInOn;
  logic txModeOk, tx36On, rx36On, irqOn;
  logic dataSelOk, dataOutOn, dataInOn, tx37On, rx37On, tmraOn;

  // Timer channel D and serial clock on bit 5
  assign chdPwmOn = chdSel & ~outEnCtl & modeA & chdPwm;
  assign chdCmpOn = chdSel & ~outEnCtl & modeA & ~chdPwm &
                    (chdIo == 3'b001 || chdIo[2:1] == 2'b01);
  assign chdCapOn = chdSel & ~chdPwm & chdIo[2];
  assign clkOutOn = ~i2cSel & clkOutCtl & ~clkInCtl;
  assign clkInOn = ~i2cSel & clkInCtl & ~clkOutCtl;

  // UART1, interrupt 1 on bit 6
  assign txModeOk = uartMode == 3'b100 || uartMode == 3'b101 ||
                    uartMode == 3'b110;
  assign tx36On = txEn & txModeOk & (route == 2'b10);
  assign rx36On = ~dir[1] & ~txEn & ~irq1En & (route == 2'b10);
  assign irqOn = ~dir[1] & irq1En & irq1Sel & ~tx36On;

  // Serial data, UART1, timer A on bit 7
  assign dataSelOk = ~dataPinSel & ~i2cSel;
  assign dataOutOn = dataSelOk & dataOutCtl & ~dataInCtl;
  assign dataInOn = dataSelOk & dataInCtl & ~dataOutCtl;
  assign tx37On = ~dataOutOn & ~dataInOn & txEn &
                  (txModeOk || uartMode == 3'b001) &
                  ((route == 2'b00) || (route == 2'b01 && altPin && txAlt));
  assign rx37On = ~dataOutOn & ~dataInOn & ~dir[2] & ~txEn &
                  (route == 2'b00) & ~timeraOe;
  assign tmraOn = ~dataOutCtl & ~dataInCtl & timeraOe & ~tx37On;

  // Per-pin drive, level and open-drain choice, by priority
  logic [2:0] drv, dat, odSel;
  p3m_func_t fn [3];

  always_comb begin
    drv[0] = 1'b1;
    dat[0] = timerChdPwmWave;
    odSel[0] = 1'b0;
    fn[0] = FN_PWM;
    if (chdPwmOn) begin
      dat[0] = timerChdPwmWave;
    end else if (chdCmpOn) begin
      dat[0] = timerChdCmpWave;
      fn[0] = FN_COMPARE;
    end else if (chdCapOn) begin
      drv[0] = 1'b0;
      fn[0] = FN_CAPTURE;
    end else if (clkOutOn) begin
      dat[0] = syncSerialClockOut;
      odSel[0] = clkOd;
      fn[0] = FN_SERCLK_OUT;
    end else if (clkInOn) begin
      drv[0] = 1'b0;
      fn[0] = FN_SERCLK_IN;
    end else begin
      drv[0] = dir[0];
      dat[0] = portData[0];
      fn[0] = dir[0] ? FN_PORT_OUT : FN_PORT_IN;
    end
    drv[1] = 1'b1;
    dat[1] = uart1TransmitData;
    odSel[1] = uartOd;
    fn[1] = FN_UART_TX;
    if (tx36On) begin
      dat[1] = uart1TransmitData;
    end else if (irqOn || rx36On) begin
      drv[1] = 1'b0;
      fn[1] = irqOn ? FN_IRQ : FN_UART_RX;
    end else begin
      drv[1] = dir[1];
      dat[1] = portData[1];
      odSel[1] = 1'b0;
      fn[1] = dir[1] ? FN_PORT_OUT : FN_PORT_IN;
    end
    drv[2] = 1'b1;
    dat[2] = syncSerialDataOut;
    odSel[2] = dataOd;
    fn[2] = FN_SDATA_OUT;
    if (dataOutOn) begin
      dat[2] = syncSerialDataOut;
    end else if (dataInOn) begin
      drv[2] = 1'b0;
      fn[2] = FN_SDATA_IN;
    end else if (tx37On) begin
      dat[2] = uart1TransmitData;
      odSel[2] = uartOd;
      fn[2] = FN_UART_TX;
    end else if (rx37On) begin
      drv[2] = 1'b0;
      odSel[2] = 1'b0;
      fn[2] = FN_UART_RX;
    end else if (tmraOn) begin
      dat[2] = timeraOutWave;
      odSel[2] = 1'b0;
      fn[2] = FN_TIMERA;
    end else begin
      drv[2] = dir[2];
      dat[2] = portData[2];
      odSel[2] = 1'b0;
      fn[2] = dir[2] ? FN_PORT_OUT : FN_PORT_IN;
    end
  end

  assign statusWord = {1'b0, pinIn, fn[2], fn[1], fn[0]};

  // ********************************
  // Pin output stages
  // ********************************
  // Registered stage puts each decode change on the pin one clock later
  for (genvar g = 0; g < NUM_PINS; g++) begin : gPin
    p3m_pin_drive uDrive (
      .sys_clk(sys_clk),
      .rst_n(rst_n),
      .drive(drv[g]),
      .data(dat[g]),
      .openDrain(odSel[g]),
      .pullAllow(pullupBit),
      .pinOut(pinOut[g]),
      .pinOe(pinOe[g]),
      .pullEn(pullupEn[g])
    );
  end

  // Registered inputs handed to the peripherals, zero when not routed, except UART receive which idles high
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      timerChdCapture <= 1'b0;
      syncSerialClockIn <= 1'b0;
      syncSerialDataIn <= 1'b0;
      uart1ReceiveData <= 1'b1;
      externalIrq1 <= 1'b0;
    end else begin
      timerChdCapture <= chdCapOn & pinIn[0];
      syncSerialClockIn <= (fn[0] == FN_SERCLK_IN) & pinIn[0];
      syncSerialDataIn <= dataInOn & pinIn[2];
      uart1ReceiveData <= rx37On ? pinIn[2] : (rx36On ? pinIn[1] : 1'b1);
      externalIrq1 <= irqOn & pinIn[1];
    end
  end

  // ********************************
  // Assertions
  // ********************************
  property p_pwm;
    @(posedge sys_clk) disable iff (!rst_n)
    chdPwmOn |=> pinOe[0] && pinOut[0] == $past(timerChdPwmWave);
  endproperty
  a_pwm: assert property (p_pwm) else $error("pwm not on pin");

  property p_cmp;
    @(posedge sys_clk) disable iff (!rst_n)
    (chdSel && !outEnCtl && modeA && !chdPwm && chdIo == 3'b011)
      |=> pinOe[0] && pinOut[0] == $past(timerChdCmpWave);
  endproperty
  a_cmp: assert property (p_cmp) else $error("compare not on pin");

  property p_cap;
    @(posedge sys_clk) disable iff (!rst_n)
    (chdSel && !chdPwm && chdIo[2]) |=> !pinOe[0] &&
      timerChdCapture == $past(pinIn[0]);
  endproperty
  a_cap: assert property (p_cap) else $error("capture path wrong");

  property p_chdOff;
    @(posedge sys_clk) disable iff (!rst_n)
    !chdSel |=> !timerChdCapture;
  endproperty
  a_chdOff: assert property (p_chdOff) else $error("timer d leaks");

  property p_clkOd;
    @(posedge sys_clk) disable iff (!rst_n)
    (fn[0] == FN_SERCLK_OUT && clkOd && syncSerialClockOut) |=> !pinOe[0];
  endproperty
  a_clkOd: assert property (p_clkOd) else $error("clock drives high");

  property p_irq;
    @(posedge sys_clk) disable iff (!rst_n)
    (dir[1] || !irq1En || !irq1Sel) |=> !externalIrq1;
  endproperty
  a_irq: assert property (p_irq) else $error("irq1 wrongly routed");

  property p_tx36;
    @(posedge sys_clk) disable iff (!rst_n)
    (txEn && uartMode == 3'b101 && route == 2'b10 && !uartOd)
      |=> pinOe[1] && pinOut[1] == $past(uart1TransmitData);
  endproperty
  a_tx36: assert property (p_tx36) else $error("tx not on bit 6");

  property p_txOd;
    @(posedge sys_clk) disable iff (!rst_n)
    (tx36On && uartOd && uart1TransmitData) |=> !pinOe[1];
  endproperty
  a_txOd: assert property (p_txOd) else $error("tx drives high");

  property p_pull;
    @(posedge sys_clk) disable iff (!rst_n)
    !pullupBit |=> pullupEn == 3'b000;
  endproperty
  a_pull: assert property (p_pull) else $error("pull-up without bit");

  property p_sdata;
    @(posedge sys_clk) disable iff (!rst_n)
    (dataPinSel || i2cSel) |=> !syncSerialDataIn;
  endproperty
  a_sdata: assert property (p_sdata) else $error("serial data leaks");

  property p_sdataOd;
    @(posedge sys_clk) disable iff (!rst_n)
    (dataOutOn && dataOd && syncSerialDataOut) |=> !pinOe[2];
  endproperty
  a_sdataOd: assert property (p_sdataOd) else $error("data drives 1");

  property p_uartOff;
    @(posedge sys_clk) disable iff (!rst_n)
    (route == 2'b11) |-> fn[2] != FN_UART_TX && fn[2] != FN_UART_RX;
  endproperty
  a_uartOff: assert property (p_uartOff) else $error("uart on bit 7");

  property p_tmra;
    @(posedge sys_clk) disable iff (!rst_n)
    (!dataOutCtl && !dataInCtl && timeraOe && !txEn)
      |=> pinOe[2] && pinOut[2] == $past(timeraOutWave);
  endproperty
  a_tmra: assert property (p_tmra) else $error("timer a not on pin");

endmodule : p3m_pin_select

`default_nettype wire

/* dv/p3m_periph_model.sv */
// Model of the peripherals beside the port 3 selector: timer, serial, UART.
// Assumes one clock and reset shared with the selector.
`default_nettype none

module p3m_periph_model (
  input wire logic sys_clk,
  input wire logic rst_n,
  output logic pwmWave,
  output logic cmpWave,
  output logic sclkWave,
  output logic sdatWave,
  output logic traWave,
  output logic txWave
);
  timeunit 1ns;
  timeprecision 1ps;

  logic [7:0] lfsr_q;

  // ************************************************************
  // Waveform sources
  // ************************************************************
  // Pseudo random bits, so a wrong source on a pin shows up quickly
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      lfsr_q <= 8'h5A;
    end else begin
      lfsr_q <= {lfsr_q[6:0], lfsr_q[7] ^ lfsr_q[5] ^ lfsr_q[4] ^ lfsr_q[3]};
    end
  end

  // Each peripheral takes its own bit
  assign pwmWave = lfsr_q[0];
  assign cmpWave = lfsr_q[2];
  assign sclkWave = lfsr_q[4];
  assign sdatWave = lfsr_q[6];
  assign traWave = lfsr_q[1];
  assign txWave = lfsr_q[5];
endmodule : p3m_periph_model

`default_nettype wire

/* dv/p3m_pin_select_tb.sv */
// Self-checking bench for the port 3 pin function selector.
// Assumes the selector in rtl/ and the peripheral model in dv/.
`default_nettype none

`include "p3m_params.svh"

module p3m_pin_select_tb;
  timeunit 1ns;
  timeprecision 1ps;

  // ************************************************************
  // Signals, instances and clock
  // ************************************************************
  logic sys_clk = 1'b0;
  logic rst_n = 1'b0;
  logic wbCyc = 1'b0;
  logic wbStb = 1'b0;
  logic wbWe = 1'b0;
  logic [7:0] wbAdr = 8'h00;
  logic [3:0] wbSel = 4'hF;
  logic [31:0] wbDatI = 32'h0000_0000;
  logic [31:0] wbDatO;
  logic wbAck;
  logic [2:0] pinIn = 3'h0;
  logic [2:0] pinOut, pinOe, pullupEn;
  logic pwmW, cmpW, sclkW, sdatW, traW, txW;
  logic capt, sclkIn, sdatIn, rxD, irq1;
  logic [5:0] waveQ;
  logic [31:0] expQ [$];
  int errorCnt = 0;
  int testsRun = 0;
  logic [7:0] ofs [4] = '{`P3M_OFS_TIMER, `P3M_OFS_SERIAL, `P3M_OFS_UART,
                          `P3M_OFS_PORT};
  logic [15:0] msk [4] = '{`P3M_MASK_TIMER, `P3M_MASK_SERIAL,
                           `P3M_MASK_UART, `P3M_MASK_PORT};
  logic [15:0] tw [11] = '{16'h000D, 16'h0015, 16'h0025, 16'h0035, 16'h0041,
                           16'h0043, 16'h0005, 16'h000F, 16'h0009, 16'h0017,
                           16'h000C};
  int tk [11] = '{1, 2, 2, 2, 3, 3, 0, 0, 0, 0, 0};

  always #2.5 sys_clk = ~sys_clk;

  p3m_pin_select #(.ADDR_W(8), .NUM_PINS(3)) dut (
    .sys_clk(sys_clk), .rst_n(rst_n), .wb_cyc_i(wbCyc), .wb_stb_i(wbStb),
    .wb_we_i(wbWe), .wb_adr_i(wbAdr), .wb_sel_i(wbSel), .wb_dat_i(wbDatI),
    .wb_dat_o(wbDatO), .wb_ack_o(wbAck), .pinIn(pinIn), .pinOut(pinOut),
    .pinOe(pinOe), .pullupEn(pullupEn), .timerChdPwmWave(pwmW),
    .timerChdCmpWave(cmpW), .timerChdCapture(capt),
    .syncSerialClockOut(sclkW), .syncSerialClockIn(sclkIn),
    .syncSerialDataOut(sdatW), .syncSerialDataIn(sdatIn),
    .timeraOutWave(traW), .uart1TransmitData(txW),
    .uart1ReceiveData(rxD), .externalIrq1(irq1));

  p3m_periph_model periph (
    .sys_clk(sys_clk), .rst_n(rst_n), .pwmWave(pwmW), .cmpWave(cmpW),
    .sclkWave(sclkW), .sdatWave(sdatW), .traWave(traW), .txWave(txW));

  // Wave levels as the selector sampled them at the last edge
  always @(posedge sys_clk) begin
    waveQ <= {txW, traW, sdatW, sclkW, cmpW, pwmW};
  end

  // ************************************************************
  // Checking and bus tasks
  // ************************************************************
  task automatic chk(input string what, input logic [31:0] seen,
                     input logic [31:0] exp);
    testsRun++;
    if (seen !== exp) begin
      errorCnt++;
      $display("MISMATCH %s expected %h seen %h", what, exp, seen);
    end
  endtask : chk

  task automatic giveVerdict();
    $display("Checks %0d mismatches %0d", testsRun, errorCnt);
    if (errorCnt == 0 && testsRun > 0) begin
      $display("Finished cleanly");
    end else begin
      $display("Finished with errors");
    end
    $finish;
  endtask : giveVerdict

  // Read results are compared when the acknowledge of a read appears
  always @(posedge sys_clk) begin
    if (wbAck === 1'b1 && wbWe === 1'b0 && expQ.size() > 0) begin
      chk("read data", wbDatO, expQ.pop_front());
    end
  end

  // One classic cycle, held until acknowledge is sampled
  task automatic wbXfer(input logic we, input logic [7:0] adr,
                        input logic [31:0] dat,
                        input logic [3:0] sel = 4'hF);
    int n;
    n = 0;
    @(posedge sys_clk);
    wbSel <= sel;
    wbCyc <= 1'b1;
    wbStb <= 1'b1;
    wbWe <= we;
    wbAdr <= adr;
    wbDatI <= dat;
    do begin
      @(posedge sys_clk);
      n++;
    end while (wbAck !== 1'b1 && n < 20);
    if (wbAck !== 1'b1) begin
      chk("bus acknowledge", 32'h0, 32'h1);
    end
    wbCyc <= 1'b0;
    wbStb <= 1'b0;
  endtask : wbXfer

  task automatic rd(input logic [7:0] adr, input logic [31:0] exp);
    expQ.push_back(exp);
    wbXfer(1'b0, adr, 32'h0000_0000);
  endtask : rd

  // Writes all four words with fresh pin levels, returns after next edge for the caller to check
  task automatic cfg(input logic [15:0] t, s, u, p);
    @(posedge sys_clk);
    pinIn <= 3'($urandom());
    wbXfer(1'b1, `P3M_OFS_TIMER, {16'h0000, t});
    wbXfer(1'b1, `P3M_OFS_SERIAL, {16'h0000, s});
    wbXfer(1'b1, `P3M_OFS_UART, {16'h0000, u});
    wbXfer(1'b1, `P3M_OFS_PORT, {16'h0000, p});
    @(posedge sys_clk);
    @(negedge sys_clk);
  endtask : cfg

  task automatic pin(input int i, input logic oe, input logic out);
    chk("pin enable", 32'(pinOe[i]), 32'(oe));
    if (oe) begin
      chk("pin level", 32'(pinOut[i]), 32'(out));
    end
  endtask : pin

  // Open drain releases high and drives low
  task automatic odChk(input int i, input logic od, input logic w);
    if (od) begin
      pin(i, !w, 1'b0);
    end else begin
      pin(i, 1'b1, w);
    end
  endtask : odChk

  // ************************************************************
  // Main sequence
  // ************************************************************
  initial begin
    logic [31:0] d;
    d = $urandom(32);
    repeat (2) @(posedge sys_clk);
    chk("reset enables", 32'(pinOe), 32'h0);
    chk("reset receive idle", 32'(rxD), 32'h1);
    rst_n <= 1'b1;
    for (int i = 0; i < 4; i++) begin
      rd(ofs[i], 32'h0000_0000);
      d = $urandom();
      wbXfer(1'b1, ofs[i], d);
      rd(ofs[i], d & {16'h0000, msk[i]});
      wbXfer(1'b1, ofs[i], 32'hFFFF_FFFF, 4'h2);
      rd(ofs[i], {16'h0000, (d[15:0] | 16'hFF00) & msk[i]});
    end
    wbXfer(1'b1, 8'h14, 32'hFFFF_FFFF);
    rd(8'h14, 32'h0000_0000);
    for (int i = 0; i < 11; i++) begin
      cfg(tw[i], 16'h0000, 16'h0000, 16'h0000);
      pin(0, tk[i] == 1 || tk[i] == 2, waveQ[tk[i] == 2]);
      chk("capture", 32'(capt), 32'(tk[i] == 3 && pinIn[0]));
    end
    for (int j = 0; j < 2; j++) begin
      cfg(16'h0000, 16'h0040 | 16'(j), 16'h0000, 16'h0000);
      odChk(0, j[0], waveQ[2]);
      cfg(16'h0000, 16'h0010 | 16'(j * 2), 16'h0000, 16'h0000);
      odChk(2, j[0], waveQ[3]);
    end
    cfg(16'h0000, 16'h0018, 16'h0000, 16'h0000);
    pin(2, 1'b0, 1'b0);
    cfg(16'h0000, 16'h0014, 16'h0000, 16'h0000);
    pin(2, 1'b0, 1'b0);
    cfg(16'h0000, 16'h0020, 16'h0000, 16'h0000);
    chk("serial data in", 32'(sdatIn), 32'(pinIn[2]));
    cfg(16'h0000, 16'h0000, 16'h0000, 16'h0200);
    pin(2, 1'b1, waveQ[4]);
    cfg(16'h0000, 16'h0000, 16'h0000, 16'h0024);
    pin(2, 1'b1, 1'b1);
    cfg(16'h0000, 16'h0000, 16'h0000, 16'h0100);
    chk("pull-ups", 32'(pullupEn), 32'h7);
    cfg(16'h0000, 16'h0000, 16'h0000, 16'h0104);
    chk("pull-ups", 32'(pullupEn), 32'h3);
    cfg(16'h0000, 16'h0000, 16'h0000, 16'h00C0);
    chk("irq1", 32'(irq1), 32'(pinIn[1]));
    pin(1, 1'b0, 1'b0);
    cfg(16'h0000, 16'h0000, 16'h0000, 16'h0040);
    chk("irq1 unselected", 32'(irq1), 32'h0);
    cfg(16'h0000, 16'h0000, 16'h0000, 16'h00C2);
    chk("irq1 output pin", 32'(irq1), 32'h0);
    for (int m = 4; m < 8; m++) begin
      cfg(16'h0000, 16'h0000, 16'h0021 | 16'(m * 2) | 16'(m == 5) << 8,
          16'h0000);
      if (m < 7) begin
        odChk(1, m == 5, waveQ[5]);
      end else begin
        pin(1, 1'b0, 1'b0);
      end
      pin(2, 1'b0, 1'b0);
    end
    cfg(16'h0000, 16'h0000, 16'h0039, 16'h0000);
    pin(1, 1'b0, 1'b0);
    pin(2, 1'b0, 1'b0);
    chk("receive idle", 32'(rxD), 32'h1);
    cfg(16'h0000, 16'h0000, 16'h0000, 16'h0000);
    chk("receive bit 7", 32'(rxD), 32'(pinIn[2]));
    rd(`P3M_OFS_STATUS, {16'h0000, 1'b0, pinIn, 12'h900});
    cfg(16'h0000, 16'h0000, 16'h0103, 16'h0000);
    odChk(2, 1'b1, waveQ[5]);
    cfg(16'h0000, 16'h0000, 16'h00D9, 16'h0000);
    pin(2, 1'b1, waveQ[5]);
    cfg(16'h0000, 16'h0000, 16'h0019, 16'h0000);
    pin(2, 1'b0, 1'b0);
    chk("receive idle", 32'(rxD), 32'h1);
    cfg(16'h0000, 16'h0080, 16'h0000, 16'h0000);
    pin(0, 1'b0, 1'b0);
    chk("serial clock in", 32'(sclkIn), 32'(pinIn[0]));
    @(negedge sys_clk);
    giveVerdict();
  end

  // Watchdog well beyond the few hundred cycles the run needs
  initial begin
    #25000;
    errorCnt++;
    giveVerdict();
  end
endmodule : p3m_pin_select_tb

`default_nettype wire
